// file: src/seven_segment_scan_controller.v
// seven-segment scan controller with AXI4-Lite register slave
//
// Notes on behaviour
// - one to four digits, eight segments
// - at most one common output active
// - light interval then blank interval, repeat
// - interrupt event at each light end
// - segment and common outputs off during blank interval
// - control bit 3 gates scan interrupt
// - bits 2:1 select digit count
// - bit 0 enables scan, resets zero
// - bit 12 selects display common drive
// - timebase is clock over prescale plus one
// - zero blank length blocks scan start
// - timing: light 7:0, blank 15:8
// - bit0 segment A ... bit7 decimal point
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "scan_defines.vh"
module seven_segment_scan_controller #(
    parameter DIGITS = 4,
    parameter TW     = 8
) (
    input  wire              aclk,             // 125 MHz clock
    input  wire              aresetn,          // synchronous reset, active low
    input  wire [7:0]        s_axi_awaddr,     // write address
    input  wire              s_axi_awvalid,    // write address valid
    output wire              s_axi_awready,    // write address ready
    input  wire [31:0]       s_axi_wdata,      // write data
    input  wire [3:0]        s_axi_wstrb,      // write strobes
    input  wire              s_axi_wvalid,     // write data valid
    output wire              s_axi_wready,     // write data ready
    output reg  [1:0]        s_axi_bresp,      // write response
    output reg               s_axi_bvalid,     // write response valid
    input  wire              s_axi_bready,     // write response ready
    input  wire [7:0]        s_axi_araddr,     // read address
    input  wire              s_axi_arvalid,    // read address valid
    output wire              s_axi_arready,    // read address ready
    output reg  [31:0]       s_axi_rdata,      // read data
    output reg  [1:0]        s_axi_rresp,      // read response
    output reg               s_axi_rvalid,     // read data valid
    input  wire              s_axi_rready,     // read data ready
    output reg  [7:0]        segment_out,      // segments A..G, decimal point
    output reg  [DIGITS-1:0] common_out,       // digit commons, high = lit
    output reg  [DIGITS-1:0] common_drive_max, // per-common strong display drive
    output wire              scan_irq          // level interrupt
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [31:0]   control_q;
    reg [TW-1:0] prescale_q;
    reg [15:0]   timing_q;
    reg [7:0]    seg_q [0:DIGITS-1];

    wire         scan_enable         = control_q[`CTL_ENABLE_BIT];
    wire [1:0]   digit_count_select  = control_q[`CTL_COUNT_HI:`CTL_COUNT_LO];
    wire         scan_irq_enable     = control_q[`CTL_IRQ_EN_BIT];
    wire         common_drive_select = control_q[`CTL_DRIVE_BIT];
    wire [7:0]   light_interval      = timing_q[`TIM_LIGHT_HI:`TIM_LIGHT_LO];
    wire [7:0]   blank_interval      = timing_q[`TIM_BLANK_HI:`TIM_BLANK_LO];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    reg        aw_held_q;
    reg        w_held_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    // a lone address or data beat is parked until its partner arrives
    // address and data taken independently, either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

    wire [7:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire aw_ok  = aw_held_q || (s_axi_awvalid && s_axi_awready);
    wire w_ok   = w_held_q || (s_axi_wvalid && s_axi_wready);
    wire wr_go  = aw_ok && w_ok && !s_axi_bvalid;

    function is_mapped;
        input [7:0] a;
        begin
            case (a)
                `OFS_CONTROL, `OFS_PRESCALE, `OFS_TIMING, `OFS_SEG0, `OFS_SEG1,
                `OFS_SEG2, `OFS_SEG3, `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR,
                `OFS_IRQ_ENABLE, `OFS_SCAN_STATE: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    merge[8*b +: 8] = nw[8*b +: 8];
                end
            end
        end
    endfunction

    // a lane-0 write landing on one register in this cycle
    function lane0_write;
        input       go;
        input [7:0] addr;
        input [7:0] target;
        input       strb0;
        begin
            lane0_write = go && (addr == target) && strb0;
        end
    endfunction

    // response waits for both beats; bready may already be high
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_addr_q    <= `RESET_BYTE;
            w_data_q     <= `RESET_WORD;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_OKAY;
        end else begin
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(wr_addr) ? `AXI_OKAY : `AXI_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // unimplemented control bits read back as zero
    wire [31:0] ctl_mask        = `CTL_WRITE_MASK;
    // widen, merge byte lanes, then keep only the implemented bits
    wire [31:0] prescale_merged = merge({{(32-TW){1'b0}}, prescale_q}, wr_data, wr_strb);
    wire [31:0] timing_merged   = merge({16'h0000, timing_q}, wr_data, wr_strb);
    integer i;

    always @(posedge aclk) begin
        if (!aresetn) begin
            control_q  <= `RESET_WORD;
            prescale_q <= {TW{1'b0}};
            timing_q   <= 16'h0000;
            for (i = 0; i < DIGITS; i = i + 1) begin
                seg_q[i] <= `RESET_BYTE;
            end
        end else if (wr_go) begin
            case (wr_addr)
                `OFS_CONTROL:  control_q  <= merge(control_q, wr_data, wr_strb) & ctl_mask;
                `OFS_PRESCALE: prescale_q <= prescale_merged[TW-1:0];
                `OFS_TIMING:   timing_q   <= timing_merged[15:0];
                default: begin
                    // segment patterns, one byte per digit
                    for (i = 0; i < DIGITS; i = i + 1) begin
                        if (wr_addr == `OFS_SEG0 + 4 * i && wr_strb[0]) begin
                            seg_q[i] <= wr_data[7:0];
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    localparam ST_IDLE  = 3'b001;
    localparam ST_LIGHT = 3'b010;
    localparam ST_BLANK = 3'b100;

    reg [2:0] state_q;
    reg [7:0] interval_q;
    reg [1:0] digit_q;
    reg       light_end;
    wire      tick;

    // a zero blank length holds the sequencer idle
    wire run = scan_enable && (blank_interval != 8'h00);

    // prescaler restarts with the sequencer, so the first light is a full tick
    scan_tick_gen #(
        .WIDTH   (TW)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (run),
        .divisor (prescale_q),
        .tick    (tick)
    );

    // a light length of zero behaves as one tick
    always @(posedge aclk) begin
        light_end <= 1'b0;
        if (!aresetn || !run) begin
            state_q    <= ST_IDLE;
            interval_q <= 8'h00;
            digit_q    <= 2'b00;
        end else if (tick) begin
            case (state_q)
                ST_IDLE: begin
                    state_q    <= ST_LIGHT;
                    interval_q <= 8'h00;
                    digit_q    <= 2'b00;
                end
                ST_LIGHT: begin
                    if (interval_q + 8'h01 >= light_interval) begin
                        state_q    <= ST_BLANK;
                        interval_q <= 8'h00;
                        light_end  <= 1'b1;
                    end else begin
                        interval_q <= interval_q + 8'h01;
                    end
                end
                ST_BLANK: begin
                    if (interval_q + 8'h01 >= blank_interval) begin
                        state_q    <= ST_LIGHT;
                        interval_q <= 8'h00;
                        // wrap after the last selected digit
                        digit_q    <= (digit_q >= digit_count_select) ? 2'b00 : digit_q + 2'b01;
                    end else begin
                        interval_q <= interval_q + 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DIGITS; g = g + 1) begin : g_com
            always @(posedge aclk) begin
                if (!aresetn) begin
                    common_out[g]       <= 1'b0;
                    common_drive_max[g] <= 1'b0;
                end else begin
                    // one-hot common, off outside lighting
                    common_out[g]       <= run && state_q == ST_LIGHT && digit_q == g;
                    common_drive_max[g] <= common_drive_select;
                end
            end
        end
    endgenerate

    // same register stage as the commons, so both switch on one edge
    always @(posedge aclk) begin
        if (!aresetn || !run || state_q != ST_LIGHT) begin
            segment_out <= 8'h00;
        end else begin
            segment_out <= seg_q[digit_q];
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // one event source: the end of each lighting interval
    wire status_bit;
    wire enable_bit;
    wire irq_raw;

    scan_irq_regs #(
        .N        (1)
    ) u_irq (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .event_in (light_end),
        .clr_we   (lane0_write(wr_go, wr_addr, `OFS_IRQ_CLEAR, wr_strb[0])),
        .clr_data (wr_data[0]),
        .en_we    (lane0_write(wr_go, wr_addr, `OFS_IRQ_ENABLE, wr_strb[0])),
        .en_data  (wr_data[0]),
        .status_q (status_bit),
        .enable_q (enable_bit),
        .irq      (irq_raw)
    );

    // status, enable register and control bit must all agree
    assign scan_irq = irq_raw && scan_irq_enable;

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    // one read in flight; unmapped offsets answer zero with an error
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `RESET_WORD;
            s_axi_rresp  <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
            case (s_axi_araddr)
                `OFS_CONTROL:    s_axi_rdata <= control_q;
                `OFS_PRESCALE:   s_axi_rdata <= {{(32-TW){1'b0}}, prescale_q};
                `OFS_TIMING:     s_axi_rdata <= {16'h0000, timing_q};
                `OFS_SEG0:       s_axi_rdata <= {24'h000000, seg_q[0]};
                `OFS_SEG1:       s_axi_rdata <= {24'h000000, seg_q[1 % DIGITS]};
                `OFS_SEG2:       s_axi_rdata <= {24'h000000, seg_q[2 % DIGITS]};
                `OFS_SEG3:       s_axi_rdata <= {24'h000000, seg_q[3 % DIGITS]};
                `OFS_IRQ_STATUS: s_axi_rdata <= {31'h0, status_bit};
                `OFS_IRQ_ENABLE: s_axi_rdata <= {31'h0, enable_bit};
                `OFS_SCAN_STATE: s_axi_rdata <= {24'h000000, 1'b0, state_q, 2'b00, digit_q};
                default:         s_axi_rdata <= `RESET_WORD;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // seven_segment_scan_controller

// file: src/scan_defines.vh
// register offsets, field positions and reset values of the scan controller
`ifndef SCAN_DEFINES_VH
`define SCAN_DEFINES_VH

`define OFS_CONTROL       8'h00
`define OFS_PRESCALE      8'h04
`define OFS_TIMING        8'h08
`define OFS_SEG0          8'h0C
`define OFS_SEG1          8'h10
`define OFS_SEG2          8'h14
`define OFS_SEG3          8'h18
`define OFS_IRQ_STATUS    8'h1C
`define OFS_IRQ_CLEAR     8'h20
`define OFS_IRQ_ENABLE    8'h24
`define OFS_SCAN_STATE    8'h28

`define CTL_ENABLE_BIT    0
`define CTL_COUNT_LO      1
`define CTL_COUNT_HI      2
`define CTL_IRQ_EN_BIT    3
`define CTL_DRIVE_BIT     12
`define CTL_WRITE_MASK    32'h0000_100F

`define TIM_LIGHT_LO      0
`define TIM_LIGHT_HI      7
`define TIM_BLANK_LO      8
`define TIM_BLANK_HI      15

`define RESET_WORD        32'h0000_0000
`define RESET_BYTE        8'h00
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

// file: src/scan_tick_gen.v
// prescaler producing one-cycle scan timebase ticks
`timescale 1ns/1ps
module scan_tick_gen #(
    parameter WIDTH = 8
) (
    input  wire             aclk,     // system clock
    input  wire             aresetn,  // synchronous reset, active low
    input  wire             run,      // counting allowed
    input  wire [WIDTH-1:0] divisor,  // prescale factor
    output reg              tick      // one pulse per divisor+1 clocks
);
    reg [WIDTH-1:0] count_q;

    // timebase = clock / (factor + 1)
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            count_q <= {WIDTH{1'b0}};
            tick    <= 1'b0;
        end else if (count_q >= divisor) begin
            count_q <= {WIDTH{1'b0}};
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end
endmodule // scan_tick_gen

// file: src/scan_irq_regs.v
// sticky interrupt status, write-one clear and enable registers
`timescale 1ns/1ps
module scan_irq_regs #(
    parameter N = 1
) (
    input  wire         aclk,       // system clock
    input  wire         aresetn,    // synchronous reset, active low
    input  wire [N-1:0] event_in,   // one-cycle event pulses
    input  wire         clr_we,     // clear register written
    input  wire [N-1:0] clr_data,   // ones clear status bits
    input  wire         en_we,      // enable register written
    input  wire [N-1:0] en_data,    // new enable value
    output reg  [N-1:0] status_q,   // sticky status
    output reg  [N-1:0] enable_q,   // enable mask
    output wire         irq         // level interrupt
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= {N{1'b0}};
            enable_q <= {N{1'b0}};
        end else begin
            // set wins over a simultaneous clear
            status_q <= (status_q & ~(clr_we ? clr_data : {N{1'b0}})) | event_in;
            if (en_we) begin
                enable_q <= en_data;
            end
        end
    end

    assign irq = |(status_q & enable_q);
endmodule // scan_irq_regs

// file: testbench/scan_checker_assertions.sv
// port-level assertions for the scan controller
`timescale 1ns/1ps
module scan_checker #(
    parameter DIGITS = 4
) (
    input wire logic              aclk,             // clock
    input wire logic              aresetn,          // reset, active low
    input wire logic              s_axi_awready,    // aw ready
    input wire logic              s_axi_wready,     // w ready
    input wire logic              s_axi_bvalid,     // b valid
    input wire logic              s_axi_bready,     // b ready
    input wire logic              s_axi_arready,    // ar ready
    input wire logic              s_axi_rvalid,     // r valid
    input wire logic              s_axi_rready,     // r ready
    input wire logic [7:0]        segment_out,      // segments
    input wire logic [DIGITS-1:0] common_out,       // commons
    input wire logic [DIGITS-1:0] common_drive_max, // drive select
    input wire logic              scan_irq          // interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [DIGITS-1:0] last_q;
    always @(posedge aclk) begin
        if (!aresetn) last_q <= '0;
        else if (common_out != '0) last_q <= common_out;
    end
    property p_one_digit; $onehot0(common_out); endproperty
    a_one_digit: assert property (p_one_digit) else $error("two digits lit");
    property p_dark_segs; common_out == '0 |-> segment_out == 8'h00; endproperty
    a_dark_segs: assert property (p_dark_segs) else $error("segments lit while dark");
    property p_blank_between; (common_out != '0) ##1 (common_out != '0) |-> $stable(common_out); endproperty
    a_blank_between: assert property (p_blank_between) else $error("digit change without blank");
    property p_order;
        (common_out != '0 && last_q != '0 && common_out != last_q)
            |-> (common_out == (last_q << 1) || common_out == 1);
    endproperty
    a_order: assert property (p_order) else $error("digit order broken");
    property p_drive; common_drive_max == '0 || common_drive_max == {DIGITS{1'b1}}; endproperty
    a_drive: assert property (p_drive) else $error("commons drive mixed");
    property p_ar; s_axi_arready == !s_axi_rvalid; endproperty
    a_ar: assert property (p_ar) else $error("arready wrong");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while response pending");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid after accept");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid after accept");
    c_last_digit: cover property (common_out[DIGITS-1]);
    c_irq: cover property (scan_irq);
    c_blank: cover property ((common_out != '0) ##1 (common_out == '0));
endmodule // scan_checker

bind seven_segment_scan_controller scan_checker #(.DIGITS(DIGITS)) scan_checker_inst (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .segment_out, .common_out, .common_drive_max, .scan_irq);

// file: testbench/display_model.sv
// behavioural multiplexed display: records what each digit shows and for how long
`timescale 1ns/1ps
module display_model (
    input wire logic       aclk,        // clock
    input wire logic [7:0] segment_out, // segment lines
    input wire logic [3:0] common_out,  // digit commons
    input wire logic       clr          // restart statistics
);
    logic [7:0] seg_seen [0:3];
    logic [3:0] prev_q;
    int         run_q, light_len, dark_len, max_dig, visits;
    always @(posedge aclk) begin
        if (clr) begin
            run_q   <= 0;
            prev_q  <= 4'h0;
            max_dig <= 0;
            visits  <= 0;
        end else begin
            // run lengths in clocks, taken when the commons change
            if (common_out !== prev_q) begin
                if (prev_q != 4'h0) light_len <= run_q;
                else dark_len <= run_q;
                run_q <= 1;
            end else run_q <= run_q + 1;
            if (common_out != 4'h0 && prev_q == 4'h0) visits <= visits + 1;
            prev_q <= common_out;
            for (int i = 0; i < 4; i++) begin
                if (common_out[i]) begin
                    seg_seen[i] <= segment_out;
                    if (i > max_dig) max_dig <= i;
                end
            end
        end
    end
endmodule // display_model

// file: testbench/tb_seven_segment_scan_controller.sv
// self-checking bench of the scan controller
`timescale 1ns/1ps
`include "scan_defines.vh"
module tb_seven_segment_scan_controller;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  resp;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  seg;
    wire  [3:0]  com, drv;
    int          failures = 0, checked = 0;
    row_t rows [10] = '{
        '{`OFS_PRESCALE, 32'hFFFF_FF01, 32'h0000_0001, `AXI_OKAY},
        '{`OFS_TIMING, 32'hFFFF_00FF, 32'h0000_00FF, `AXI_OKAY},
        '{`OFS_SEG0, 32'hABCD_123F, 32'h0000_003F, `AXI_OKAY},
        '{`OFS_SEG1, 32'h5555_0006, 32'h0000_0006, `AXI_OKAY},
        '{`OFS_SEG2, 32'h0000_01DB, 32'h0000_00DB, `AXI_OKAY},
        '{`OFS_SEG3, 32'h1234_56CF, 32'h0000_00CF, `AXI_OKAY},
        '{`OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0001, `AXI_OKAY},
        '{`OFS_IRQ_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000, `AXI_OKAY},
        '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000, `AXI_SLVERR},
        '{`OFS_CONTROL, 32'hFFFF_FFFF, 32'h0000_100F, `AXI_OKAY}};

    always #4 aclk = ~aclk;

    seven_segment_scan_controller seven_segment_scan_controller_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .segment_out(seg), .common_out(com),
        .common_drive_max(drv), .scan_irq(irq));
    display_model display_model_inst (.aclk(aclk), .segment_out(seg), .common_out(com), .clr(clr));

    task conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // both channels offered together, each released at its own handshake
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            {ta, tw, tb} = {awvalid && awready, wvalid && wready, bvalid};
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        failures++;
        conclude();
    endtask
    task rdr(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            {ta, tr} = {arvalid && arready, rvalid};
            {rd, resp} = {rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        failures++;
        conclude();
    endtask
    task restart_display(input int n);
        @(posedge aclk) clr <= 1'b1;
        // statistics stay cleared until the digit lit before the change goes dark
        for (int i = 0; i < 3000; i++) begin
            @(negedge aclk);
            if (clr && com == 4'h0) @(posedge aclk) clr <= 1'b0;
            else if (!clr && display_model_inst.visits >= n) return;
        end
        failures++;
        conclude();
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({drv, com, seg, irq}, 32'h0);
        rdr(`OFS_CONTROL);
        chk(rd, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(resp, rows[i].r);
            rdr(rows[i].a);
            chk(rd, rows[i].e);
            chk(resp, rows[i].r);
        end
        // enabled with a zero blank length: nothing may light
        repeat (40) @(negedge aclk) chk(com, 4'h0);
        $display("register table test done");
        wr(`OFS_TIMING, 32'h0000_0203);
        restart_display(9);
        for (int i = 0; i < 4; i++) chk(display_model_inst.seg_seen[i], rows[2 + i].e);
        chk(display_model_inst.light_len, 6);
        chk(display_model_inst.dark_len, 4);
        chk(display_model_inst.max_dig, 3);
        chk(drv, 4'hF);
        chk(irq, 1'b1);
        rdr(`OFS_IRQ_STATUS);
        chk(rd, 32'h1);
        $display("four digit scan test done");
        for (int c = 0; c < 3; c++) begin
            wr(`OFS_CONTROL, (c << 1) | 1);
            restart_display(6);
            chk(display_model_inst.max_dig, c);
            chk(drv, 4'h0);
            chk(irq, 1'b0);
        end
        $display("digit count test done");
        wr(`OFS_CONTROL, 32'h0000_0008);
        repeat (2) @(negedge aclk);
        chk({com, seg}, 12'h0);
        rdr(`OFS_SCAN_STATE);
        chk(rd, 32'h10);
        chk(irq, 1'b1);
        wr(`OFS_IRQ_ENABLE, 32'h0);
        @(negedge aclk) chk(irq, 1'b0);
        wr(`OFS_IRQ_ENABLE, 32'h1);
        @(negedge aclk) chk(irq, 1'b1);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        @(negedge aclk) chk(irq, 1'b0);
        rdr(`OFS_IRQ_STATUS);
        chk(rd, 32'h0);
        $display("disable and interrupt test done");
        conclude();
    end
endmodule // tb_seven_segment_scan_controller
